// file: hdl/ptf_fetch_redirect.v
// ptf_fetch_redirect.v: fetch address, prefetch queue and transfer redirect
// assumes a byte memory answering one request at a time with mem_ack
// Overview of operation
// - fetch address is segment base plus offset
// - segment base register marks 64k code region
// - offset measured from segment start
// - prefetch ahead into instruction queue
// - transfer flushes queue, abandons sequential flow
// - first byte after transfer bypasses queue
// - only interrupt transfers may change flags
// - unsigned above/below jump conditions
// - signed greater/less jump conditions
// - single flag jumps, set and clear
`timescale 1ns/10ps
`default_nettype none
`include "ptf_defs.vh"

module ptf_fetch_redirect #(
    parameter QDEPTH = 4,
    parameter QPTR_W = 2
) (
    input  wire        mclk,
    input  wire        rst,
    input  wire        xfer_req,
    input  wire [1:0]  xfer_kind,
    input  wire [3:0]  xfer_cond,
    input  wire        xfer_far,
    input  wire [15:0] xfer_seg,
    input  wire [15:0] xfer_off,
    input  wire        flag_carry,
    input  wire        flag_zero,
    input  wire        flag_sign,
    input  wire        flag_overflow,
    input  wire        flag_parity,
    input  wire        eu_take,
    output reg         eu_valid,
    output reg  [7:0]  eu_byte,
    output reg         eu_direct,
    output reg         xfer_taken,
    output reg         flags_write_ok,
    output reg         mem_req,
    output reg  [19:0] mem_addr,
    input  wire        mem_ack,
    input  wire [7:0]  mem_data,
    output reg  [15:0] code_seg,
    output reg  [15:0] instr_off
);

    // ***********************************************
    // state
    // ***********************************************
    localparam ST_FILL   = 1'b0;
    localparam ST_DIRECT = 1'b1;

    wire              cond_true;
    wire              take_now;
    wire              q_full;
    wire              q_empty;
    wire              q_pop;
    wire              q_push;
    wire [19:0]       fetch_addr;
    reg  [7:0]        q_mem [0:QDEPTH-1];
    reg  [QPTR_W-1:0] q_rd_reg;
    reg  [QPTR_W-1:0] q_wr_reg;
    reg  [QPTR_W:0]   q_cnt_reg;
    reg  [15:0]       fetch_off_reg;
    reg               state_reg;
    reg               mem_busy_reg;
    wire              ack_ok;
    wire              direct_pending;
    wire              eu_consume;
    wire              head_load;

    // ***********************************************
    // condition evaluation
    // ***********************************************
    ptf_cond_eval ptf_cond_eval_i (
        .cond_sel      (xfer_cond),
        .flag_carry    (flag_carry),
        .flag_zero     (flag_zero),
        .flag_sign     (flag_sign),
        .flag_overflow (flag_overflow),
        .flag_parity   (flag_parity),
        .cond_true     (cond_true)
    );

    assign take_now = xfer_req & ((xfer_kind != `PTF_KIND_COND) | cond_true);

    // ***********************************************
    // address formation
    // ***********************************************
    // segment shifted plus offset
    assign fetch_addr = {code_seg, 4'h0} + {4'h0, fetch_off_reg};

    // ***********************************************
    // memory acknowledge
    // ***********************************************
    // a flushed fetch may still be answered after a transfer
    // ack while the request pulse stands belongs to that old fetch
    assign ack_ok = mem_busy_reg & mem_ack & ~mem_req;

    // ***********************************************
    // queue status and execution unit handshake
    // ***********************************************
    assign q_full         = (q_cnt_reg == QDEPTH[QPTR_W:0]);
    assign q_empty        = (q_cnt_reg == {(QPTR_W+1){1'b0}});
    assign eu_consume     = eu_take & eu_valid;
    assign q_pop          = eu_consume & ~eu_direct;
    // bypass byte holds off refill until taken
    assign direct_pending = eu_valid & eu_direct & ~eu_take;
    assign q_push         = ack_ok & (state_reg == ST_FILL) & ~take_now;
    // next head shown once the output slot frees
    assign head_load      = (~eu_valid | eu_consume) & ~q_empty & ~q_pop
                            & ~(ack_ok & (state_reg == ST_DIRECT));

    // ***********************************************
    // transfer status outputs
    // ***********************************************
    always @(posedge mclk) begin
        if (rst) begin
            xfer_taken     <= 1'b0;
            flags_write_ok <= 1'b0;
        end else begin
            xfer_taken     <= take_now;
            flags_write_ok <= xfer_req & (xfer_kind == `PTF_KIND_INTR);
        end
    end

    // ***********************************************
    // queue storage
    // ***********************************************
    // no reset: contents are qualified by the count
    always @(posedge mclk) begin
        if (~rst & q_push)
            q_mem[q_wr_reg] <= mem_data;
    end

    // ***********************************************
    // queue pointers and count
    // ***********************************************
    always @(posedge mclk) begin
        if (rst | take_now) begin
            q_rd_reg  <= {QPTR_W{1'b0}};
            q_wr_reg  <= {QPTR_W{1'b0}};
            q_cnt_reg <= {(QPTR_W+1){1'b0}};
        end else begin
            if (q_push)
                q_wr_reg <= q_wr_reg + {{(QPTR_W-1){1'b0}}, 1'b1};
            if (q_pop)
                q_rd_reg <= q_rd_reg + {{(QPTR_W-1){1'b0}}, 1'b1};
            // count includes the byte shown to the execution unit
            if (q_push & ~q_pop)
                q_cnt_reg <= q_cnt_reg + {{QPTR_W{1'b0}}, 1'b1};
            else if (q_pop & ~q_push)
                q_cnt_reg <= q_cnt_reg - {{QPTR_W{1'b0}}, 1'b1};
        end
    end

    // ***********************************************
    // transfer, fetch sequencing and output slot
    // ***********************************************
    always @(posedge mclk) begin
        if (rst) begin
            code_seg      <= `PTF_CS_RESET;
            instr_off     <= `PTF_IP_RESET;
            fetch_off_reg <= `PTF_IP_RESET;
            state_reg     <= ST_FILL;
            mem_busy_reg  <= 1'b0;
            mem_req       <= 1'b0;
            mem_addr      <= 20'h00000;
            eu_valid      <= 1'b0;
            eu_byte       <= 8'h00;
            eu_direct     <= 1'b0;
        end else begin
            // request is a one-cycle pulse
            mem_req <= 1'b0;
            if (take_now) begin
                if (xfer_far)
                    code_seg <= xfer_seg;
                instr_off     <= xfer_off;
                fetch_off_reg <= xfer_off;
                eu_valid      <= 1'b0;
                eu_direct     <= 1'b0;
                state_reg     <= ST_DIRECT;
                mem_busy_reg  <= 1'b0;
            end else begin
                // offset follows each byte the execution unit takes
                if (eu_consume) begin
                    instr_off <= instr_off + 16'h0001;
                    eu_valid  <= 1'b0;
                end
                if (ack_ok) begin
                    mem_busy_reg  <= 1'b0;
                    fetch_off_reg <= fetch_off_reg + 16'h0001;
                    // first byte straight to execution unit
                    if (state_reg == ST_DIRECT) begin
                        eu_valid  <= 1'b1;
                        eu_direct <= 1'b1;
                        eu_byte   <= mem_data;
                        state_reg <= ST_FILL;
                    end
                end else if (~mem_busy_reg & ~direct_pending) begin
                    // bypass fetch first, then refill while room remains
                    if ((state_reg == ST_DIRECT) | ~q_full) begin
                        mem_req      <= 1'b1;
                        mem_addr     <= fetch_addr;
                        mem_busy_reg <= 1'b1;
                    end
                end
                // present queue head when the slot is free
                if (head_load) begin
                    eu_valid  <= 1'b1;
                    eu_direct <= 1'b0;
                    eu_byte   <= q_mem[q_rd_reg];
                end
            end
        end
    end

endmodule
`default_nettype wire

// file: hdl/ptf_defs.vh
// ptf_defs.vh: constants for the program transfer fetch redirect block
// assumes inclusion by bare name from design files
`ifndef PTF_DEFS_VH
`define PTF_DEFS_VH

// ***********************************************
// address formation
// ***********************************************
`define PTF_SEG_SHIFT      4
`define PTF_ADDR_W         20
`define PTF_WORD_W         16
`define PTF_CS_RESET       16'hFFFF
`define PTF_IP_RESET       16'h0000

// ***********************************************
// condition codes (4-bit select)
// ***********************************************
`define PTF_CC_OVERFLOW    4'h0
`define PTF_CC_NO_OVERFLOW 4'h1
`define PTF_CC_BELOW       4'h2
`define PTF_CC_ABOVE_EQ    4'h3
`define PTF_CC_ZERO        4'h4
`define PTF_CC_NOT_ZERO    4'h5
`define PTF_CC_BELOW_EQ    4'h6
`define PTF_CC_ABOVE       4'h7
`define PTF_CC_SIGN        4'h8
`define PTF_CC_NO_SIGN     4'h9
`define PTF_CC_PAR_EVEN    4'hA
`define PTF_CC_PAR_ODD     4'hB
`define PTF_CC_LESS        4'hC
`define PTF_CC_GREATER_EQ  4'hD
`define PTF_CC_LESS_EQ     4'hE
`define PTF_CC_GREATER     4'hF

// ***********************************************
// transfer kinds
// ***********************************************
`define PTF_KIND_UNCOND    2'h0
`define PTF_KIND_COND      2'h1
`define PTF_KIND_ITER      2'h2
`define PTF_KIND_INTR      2'h3

`endif

// file: hdl/ptf_cond_eval.v
// ptf_cond_eval.v: combinational jump condition evaluator
// assumes flags come from the execution unit on the same clock
`timescale 1ns/10ps
`default_nettype none
`include "ptf_defs.vh"

module ptf_cond_eval (
    input  wire [3:0] cond_sel,
    input  wire       flag_carry,
    input  wire       flag_zero,
    input  wire       flag_sign,
    input  wire       flag_overflow,
    input  wire       flag_parity,
    output reg        cond_true
);

    always @* begin
        case (cond_sel)
            `PTF_CC_OVERFLOW:    cond_true = flag_overflow;
            `PTF_CC_NO_OVERFLOW: cond_true = ~flag_overflow;
            `PTF_CC_ZERO:        cond_true = flag_zero;
            `PTF_CC_NOT_ZERO:    cond_true = ~flag_zero;
            `PTF_CC_SIGN:        cond_true = flag_sign;
            `PTF_CC_NO_SIGN:     cond_true = ~flag_sign;
            `PTF_CC_PAR_EVEN:    cond_true = flag_parity;
            `PTF_CC_PAR_ODD:     cond_true = ~flag_parity;
            `PTF_CC_BELOW:       cond_true = flag_carry;
            `PTF_CC_ABOVE_EQ:    cond_true = ~flag_carry;
            `PTF_CC_BELOW_EQ:    cond_true = flag_carry | flag_zero;
            `PTF_CC_ABOVE:       cond_true = ~(flag_carry | flag_zero);
            `PTF_CC_LESS:        cond_true = flag_sign ^ flag_overflow;
            `PTF_CC_GREATER_EQ:  cond_true = ~(flag_sign ^ flag_overflow);
            `PTF_CC_LESS_EQ:     cond_true = (flag_sign ^ flag_overflow) | flag_zero;
            default:             cond_true = ~((flag_sign ^ flag_overflow) | flag_zero);
        endcase
    end

endmodule
`default_nettype wire

// file: sim/ptf_mem_model.sv
// model: byte memory behind the fetch port
// assumes one request outstanding; slow adds wait cycles
`timescale 1ns/10ps
`default_nettype none
module ptf_mem_model (
    input  wire logic        mclk, rst, slow, mem_req,
    input  wire logic [19:0] mem_addr,
    output var  logic        mem_ack,
    output var  logic [7:0]  mem_data
);
    logic [1:0]  wait_reg;
    logic        busy_reg;
    logic [19:0] addr_reg;
    // byte is the low address byte; idle data keeps toggling
    always @(posedge mclk) begin
        mem_ack <= 1'h0;
        mem_data <= ~mem_data;
        if (rst) begin
            busy_reg <= 1'h0;
            mem_data <= 8'h00;
        end else if (mem_req) begin
            busy_reg <= 1'h1;
            addr_reg <= mem_addr;
            wait_reg <= slow ? 2'h3 : 2'h0;
        end else if (busy_reg && wait_reg != 2'h0) begin
            wait_reg <= wait_reg - 2'h1;
        end else if (busy_reg) begin
            busy_reg <= 1'h0;
            mem_ack <= 1'h1;
            mem_data <= addr_reg[7:0];
        end
    end
endmodule
`default_nettype wire

// file: sim/ptf_chk.sv
// checker: port assertions for the fetch redirect block
// assumes bind onto ptf_fetch_redirect, one clock, sync reset
`timescale 1ns/10ps
`default_nettype none
module ptf_chk (
    input wire logic        mclk, rst, xfer_req, xfer_far, xfer_taken, flags_write_ok, eu_take,
    input wire logic        flag_carry, flag_zero, flag_sign, flag_overflow, flag_parity,
    input wire logic        eu_valid, eu_direct, mem_req,
    input wire logic [1:0]  xfer_kind,
    input wire logic [3:0]  xfer_cond,
    input wire logic [15:0] xfer_seg, xfer_off, code_seg, instr_off,
    input wire logic [19:0] mem_addr
);
    wire logic       sx = flag_sign ^ flag_overflow;
    wire logic [7:0] t = {sx | flag_zero, sx, flag_parity, flag_sign,
                          flag_carry | flag_zero, flag_zero, flag_carry, flag_overflow};
    wire logic       ok = t[xfer_cond[3:1]] ^ xfer_cond[0];
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence redirect_s;
        xfer_taken ##1 mem_req;
    endsequence
    next_fetch_a: assert property (xfer_taken && !(xfer_req && (xfer_kind != 2'h1 || ok)) |=> mem_req)
        else $error("no fetch after redirect");
    addr_form_a: assert property (redirect_s |-> mem_addr == {code_seg, 4'h0} + {4'h0, instr_off})
        else $error("fetch address wrong");
    queue_flush_a: assert property (xfer_taken |-> !eu_valid)
        else $error("queue not flushed");
    direct_first_a: assert property (eu_valid && eu_direct |-> !mem_req)
        else $error("refill before direct byte taken");
    flags_gate_a: assert property (flags_write_ok == ($past(xfer_req) && $past(xfer_kind) == 2'h3))
        else $error("flag write not tied to interrupt kind");
    cond_eval_a: assert property (xfer_req && xfer_kind == 2'h1 |=> xfer_taken == $past(ok))
        else $error("condition decision wrong");
    uncond_take_a: assert property (xfer_req && xfer_kind != 2'h1 |=> xfer_taken)
        else $error("transfer not taken");
    target_load_a: assert property (xfer_req && (xfer_kind != 2'h1 || ok) |=> instr_off == $past(xfer_off)
        && code_seg == ($past(xfer_far) ? $past(xfer_seg) : $past(code_seg)))
        else $error("target not loaded");
    keep_seq_a: assert property (xfer_req && xfer_kind == 2'h1 && !ok |=> $stable(code_seg)
        && (eu_valid || !$past(eu_valid) || $past(eu_take)))
        else $error("false condition disturbed fetch");
endmodule
bind ptf_fetch_redirect ptf_chk ptf_chk_i (.mclk(mclk), .rst(rst), .xfer_req(xfer_req), .xfer_far(xfer_far),
    .xfer_taken(xfer_taken), .flags_write_ok(flags_write_ok), .eu_take(eu_take), .flag_carry(flag_carry),
    .flag_zero(flag_zero), .flag_sign(flag_sign), .flag_overflow(flag_overflow), .flag_parity(flag_parity),
    .eu_valid(eu_valid), .eu_direct(eu_direct), .mem_req(mem_req), .xfer_kind(xfer_kind),
    .xfer_cond(xfer_cond), .xfer_seg(xfer_seg), .xfer_off(xfer_off), .code_seg(code_seg),
    .instr_off(instr_off), .mem_addr(mem_addr));
`default_nettype wire

// file: sim/ptf_fetch_redirect_tb.sv
// testbench: redirects, condition codes, refill after transfer
// assumes memory model and checker compiled before it
`timescale 1ns/10ps
`default_nettype none
module ptf_fetch_redirect_tb;
    logic        mclk = 0, rst = 1, xfer_req = 0, xfer_far = 0, eu_take = 0, slow = 0;
    logic [1:0]  xfer_kind = 0;
    logic [3:0]  xfer_cond = 0;
    logic [4:0]  flg = 0;
    logic [15:0] xfer_seg = 0, xfer_off = 0;
    wire logic   eu_valid, eu_direct, xfer_taken, flags_write_ok, mem_req, mem_ack;
    wire logic [7:0]  eu_byte, mem_data;
    wire logic [19:0] mem_addr;
    wire logic [15:0] code_seg, instr_off;
    int bad_count = 0, tests_run = 0;
    ptf_fetch_redirect ptf_fetch_redirect_i (.mclk(mclk), .rst(rst), .xfer_req(xfer_req),
        .xfer_kind(xfer_kind), .xfer_cond(xfer_cond), .xfer_far(xfer_far), .xfer_seg(xfer_seg),
        .xfer_off(xfer_off), .flag_carry(flg[4]), .flag_zero(flg[3]), .flag_sign(flg[2]),
        .flag_overflow(flg[1]), .flag_parity(flg[0]), .eu_take(eu_take), .eu_valid(eu_valid),
        .eu_byte(eu_byte), .eu_direct(eu_direct), .xfer_taken(xfer_taken), .flags_write_ok(flags_write_ok),
        .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_data(mem_data),
        .code_seg(code_seg), .instr_off(instr_off));
    ptf_mem_model ptf_mem_model_i (.mclk(mclk), .rst(rst), .slow(slow), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_data(mem_data));
    initial forever #12.5 mclk = ~mclk;
    task automatic check(string what, logic [19:0] seen, logic [19:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic results;
        $display("mismatches %0d in %0d checks", bad_count, tests_run);
        if (bad_count == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic take(logic [7:0] exp, logic dir);
        int n;
        n = 0;
        @(negedge mclk);
        while (eu_valid !== 1'h1 && n < 40) begin
            @(negedge mclk);
            n++;
        end
        check("eu_valid", eu_valid, 1'h1);
        check("eu_byte", eu_byte, exp);
        check("eu_direct", eu_direct, dir);
        eu_take = 1;
        @(negedge mclk);
        eu_take = 0;
    endtask
    task automatic xfer(logic [1:0] k, logic [3:0] c, logic f, logic [15:0] s, logic [15:0] o, logic t);
        logic [15:0] cs, io, n;
        logic [19:0] a;
        cs = code_seg;
        io = instr_off;
        n = o + 16'h1;
        {xfer_kind, xfer_cond, xfer_far, xfer_seg, xfer_off, xfer_req} = {k, c, f, s, o, 1'h1};
        @(negedge mclk);
        xfer_req = 0;
        check("xfer_taken", xfer_taken, t);
        check("flags_write_ok", flags_write_ok, k == 2'h3);
        check("code_seg", code_seg, t && f ? s : cs);
        check("instr_off", instr_off, t ? o : io);
        if (t) begin
            a = {f ? s : cs, 4'h0} + o;
            take(a[7:0], 1);
            a = {f ? s : cs, 4'h0} + n;
            take(a[7:0], 0);
            check("instr_off", instr_off, 16'(n + 16'h1));
        end else begin
            @(negedge mclk);
        end
    endtask
    initial begin
        repeat (6) @(negedge mclk);
        rst = 0;
        check("code_seg", code_seg, 16'hFFFF);
        take(8'hF0, 0);
        take(8'hF1, 0);
        for (int i = 0; i < 32; i++) begin
            flg = {5{i[4]}};
            xfer(1, i[3:0], 0, 0, 16'h0100 + i, i[0] ^ (i[4] && i[3:1] != 3'h6));
        end
        flg = 5'h04;
        for (int i = 0; i < 16; i++)
            xfer(1, i[3:0], 0, 0, 16'h0200 + i, i[0] ^ (i[3] && i[2:1] != 2'h1));
        slow = 1;
        xfer(0, 0, 1, 16'h1234, 16'hFFFF, 1);
        xfer(2, 0, 0, 0, 16'h0010, 1);
        xfer(3, 0, 1, 16'hF000, 16'h0008, 1);
        results;
    end
    initial begin
        #500000;
        bad_count++;
        results;
    end
endmodule
`default_nettype wire
